/* File: hdl/rfm_pkg.sv */
`default_nettype none
package rfm_pkg;

	// ========================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_BAUD   = 8'h04;
	localparam logic [7:0] OFF_FLOW   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_CMD    = 8'h10;

	// ========================================
	// field positions
	localparam int CTRL_CTS_LSB   = 0;
	localparam int CTRL_RTS_LSB   = 2;
	localparam int CTRL_SLEEP_EN  = 4;
	localparam int CTRL_RXIND_EN  = 5;
	localparam int CTRL_CMD_MODE  = 6;
	localparam int FLOW_ON_LSB    = 8;
	localparam int ST_FRAME_ERR   = 5;
	localparam int ST_OVERFLOW    = 7;
	localparam int ST_LEVEL_LSB   = 8;

	// ========================================
	// modes of the two flow-control pins
	localparam logic [1:0] CTS_FLOW   = 2'h0;
	localparam logic [1:0] CTS_RS485_2W = 2'h1;
	localparam logic [1:0] CTS_RS485_4W = 2'h2;
	localparam logic [1:0] RTS_UNUSED = 2'h0;
	localparam logic [1:0] RTS_FLOW   = 2'h1;
	localparam logic [1:0] RTS_CMD    = 2'h2;

	// ========================================
	// reset values and constants
	localparam logic [7:0] FC_OFF_RST = 8'h11;
	localparam logic [7:0] FC_ON_RST  = 8'h22;
	localparam logic [7:0] PLUS_CHAR  = 8'h2B;
	localparam logic [1:0] PLUS_LAST  = 2'h2;
	localparam logic [4:0] PIN_RST    = 5'h1D;
	localparam int         IB_DEPTH   = 64;
	localparam int         DO_DEPTH   = 8;

	// ========================================
	// timing
	localparam int CLK_HZ    = 100_000_000;
	localparam int BAUD_RATE = 9600;
	localparam int BAUD_DIV  = CLK_HZ / BAUD_RATE;

	typedef struct packed {
		logic       rx_ind_en;
		logic       sleep_en;
		logic [1:0] rts_mode;
		logic [1:0] cts_mode;
	} rfm_ctrl_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rfm_rx_state_t;
	typedef enum logic {TX_IDLE, TX_BITS} rfm_tx_state_t;

endpackage
`default_nettype wire

/* File: hdl/rfm_pin_if.sv */
`default_nettype none

// ========================================
// fifo
module rfm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	input  wire logic                       ce_i,
	input  wire logic                       clr_i,
	input  wire logic                       in_valid_i,
	input  wire logic [WIDTH-1:0]           in_data_i,
	output logic                            in_ready_o,
	output logic                            out_valid_o,
	output logic [WIDTH-1:0]                out_data_o,
	input  wire logic                       out_ready_i,
	output logic [$clog2(DEPTH+1)-1:0]      level_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [LW-1:0]    next_level;
	logic             push;
	logic             pop;

	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;
	assign out_valid_o = (level_o != '0);
	assign out_data_o  = mem[rd_ptr];

	always_comb
	begin
		next_level = level_o;
		if (push && !pop)
			next_level = level_o + LW'(1);
		else if (pop && !push)
			next_level = level_o - LW'(1);
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			level_o    <= '0;
			in_ready_o <= 1'b1;
		end
		else if (ce_i)
		begin
			level_o    <= clr_i ? '0 : next_level;
			in_ready_o <= clr_i ? 1'b1 : (next_level != LW'(DEPTH));
		end
	end

	// pointers wrap by compare so any depth works, not only powers of two
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (ce_i)
		begin
			if (clr_i)
			begin
				wr_ptr <= '0;
				rd_ptr <= '0;
			end
			else
			begin
				if (push)
					wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
				if (pop)
					rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (ce_i && push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule

// ========================================
// pin interface top
module rfm_pin_if #(
	parameter int BAUD_DIV = rfm_pkg::BAUD_DIV,
	parameter int IB_DEPTH = rfm_pkg::IB_DEPTH,
	parameter int DO_DEPTH = rfm_pkg::DO_DEPTH
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        serial_in_pin_i,
	output logic             serial_out_pin_o,
	output logic             aux_output_two_o,
	input  wire logic        aux_input_two_i,
	input  wire logic        aux_input_three_i,
	input  wire logic        reset_pin_n_i,
	input  wire logic        config_n_i,
	output logic             receive_indicator_o,
	output logic             transmit_power_status_o,
	output logic             sleep_o,
	output logic             cmd_mode_o,
	output logic [7:0]       rf_tx_data_o,
	output logic             rf_tx_valid_o,
	input  wire logic        rf_tx_ready_i,
	input  wire logic        rf_tx_busy_i,
	input  wire logic [7:0]  rf_rx_data_i,
	input  wire logic        rf_rx_valid_i,
	output logic             rf_rx_ready_o,
	input  wire logic        rf_rx_active_i
);
	localparam int DLW = $clog2(IB_DEPTH+1);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	// ========================================
	// pin synchronisers
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic       rx_s;
	logic       aux2_s;
	logic       aux3_s;
	logic       config_n_s;
	logic       clr;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pin_meta <= rfm_pkg::PIN_RST;
			pin_sync <= rfm_pkg::PIN_RST;
		end
		else if (ce_i)
		begin
			pin_meta <= {reset_pin_n_i, config_n_i, aux_input_three_i, aux_input_two_i,
				serial_in_pin_i};
			pin_sync <= pin_meta;
		end
	end

	assign rx_s       = pin_sync[0];
	assign aux2_s     = pin_sync[1];
	assign aux3_s     = pin_sync[2];
	assign config_n_s = pin_sync[3];
	assign clr        = ~pin_sync[4];

	// ========================================
	// registers
	rfm_pkg::rfm_ctrl_t ctrl;
	logic [15:0]        baud;
	logic [7:0]         fc_off;
	logic [7:0]         fc_on;
	logic               frame_err;
	logic               overflow;
	logic [7:0]         cmd_byte;
	logic               cmd_valid;
	logic               acc;
	logic               wr_ctrl;
	logic               wr_status;
	logic               rd_cmd;

	// one wait state so read data comes from a flop
	assign acc       = psel_i & penable_i & pready_o;
	assign wr_ctrl   = acc & pwrite_i & hit(paddr_i, rfm_pkg::OFF_CTRL);
	assign wr_status = acc & pwrite_i & hit(paddr_i, rfm_pkg::OFF_STATUS);
	assign rd_cmd    = acc & ~pwrite_i & hit(paddr_i, rfm_pkg::OFF_CMD);

	logic             rx_done;
	logic             rx_ferr;
	logic [7:0]       rx_byte;
	logic             cmd_sel;
	logic             plus_hit;
	logic [DLW-1:0]   ib_level;
	logic             ib_ready;
	logic             cts_hold;
	logic             tx_busy;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			pready_o  <= psel_i & penable_i & ~pready_o;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			if (psel_i && penable_i && !pready_o)
			begin
				if (hit(paddr_i, rfm_pkg::OFF_CTRL))
					prdata_o <= 32'({cmd_mode_o, ctrl});
				else if (hit(paddr_i, rfm_pkg::OFF_BAUD))
					prdata_o <= 32'(baud);
				else if (hit(paddr_i, rfm_pkg::OFF_FLOW))
					prdata_o <= 32'({fc_on, fc_off});
				else if (hit(paddr_i, rfm_pkg::OFF_STATUS))
					prdata_o <= 32'({8'(ib_level), overflow, cmd_valid, frame_err,
						rf_tx_valid_o | rf_tx_busy_i, rf_rx_active_i, cts_hold,
						sleep_o, cmd_mode_o});
				else if (hit(paddr_i, rfm_pkg::OFF_CMD))
					prdata_o <= 32'(cmd_byte);
				else
					pslverr_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctrl   <= '0;
			baud   <= 16'(BAUD_DIV);
			fc_off <= rfm_pkg::FC_OFF_RST;
			fc_on  <= rfm_pkg::FC_ON_RST;
		end
		else if (ce_i)
		begin
			if (clr)
			begin
				ctrl   <= '0;
				baud   <= 16'(BAUD_DIV);
				fc_off <= rfm_pkg::FC_OFF_RST;
				fc_on  <= rfm_pkg::FC_ON_RST;
			end
			else if (acc && pwrite_i)
			begin
				if (hit(paddr_i, rfm_pkg::OFF_CTRL))
					ctrl <= pwdata_i[5:0];
				if (hit(paddr_i, rfm_pkg::OFF_BAUD))
					baud <= pwdata_i[15:0];
				if (hit(paddr_i, rfm_pkg::OFF_FLOW))
				begin
					fc_off <= pwdata_i[7:0];
					fc_on  <= pwdata_i[rfm_pkg::FLOW_ON_LSB +: 8];
				end
			end
		end
	end

	// sticky flags: hardware set beats a same-cycle software clear
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			frame_err <= 1'b0;
			overflow  <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_byte  <= 8'h00;
		end
		else if (ce_i)
		begin
			if (clr)
			begin
				frame_err <= 1'b0;
				overflow  <= 1'b0;
				cmd_valid <= 1'b0;
				cmd_byte  <= 8'h00;
			end
			else
			begin
				if (rx_ferr)
					frame_err <= 1'b1;
				else if (wr_status && pwdata_i[rfm_pkg::ST_FRAME_ERR])
					frame_err <= 1'b0;
				if (rx_done && !cmd_sel && !ib_ready)
					overflow <= 1'b1;
				else if (wr_status && pwdata_i[rfm_pkg::ST_OVERFLOW])
					overflow <= 1'b0;
				if (rx_done && cmd_sel)
				begin
					cmd_byte  <= rx_byte;
					cmd_valid <= 1'b1;
				end
				else if (rd_cmd)
					cmd_valid <= 1'b0;
			end
		end
	end

	// ========================================
	// command mode: strap, escape sequence, software
	logic [1:0] strap_wait;
	logic [1:0] plus_cnt;

	assign plus_hit = rx_done & ~cmd_mode_o & (rx_byte == rfm_pkg::PLUS_CHAR)
		& (plus_cnt == rfm_pkg::PLUS_LAST);
	assign cmd_sel  = cmd_mode_o | ((ctrl.rts_mode == rfm_pkg::RTS_CMD) & ~aux2_s);

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			strap_wait <= 2'h0;
			plus_cnt   <= 2'h0;
			cmd_mode_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (clr)
			begin
				strap_wait <= 2'h0;
				plus_cnt   <= 2'h0;
				cmd_mode_o <= 1'b0;
			end
			else
			begin
				// wait for the synchroniser to carry the real strap level
				if (strap_wait != 2'h3)
					strap_wait <= strap_wait + 2'h1;
				if (rx_done && !cmd_mode_o)
					plus_cnt <= (rx_byte == rfm_pkg::PLUS_CHAR && !plus_hit) ?
						plus_cnt + 2'h1 : 2'h0;
				if (strap_wait == 2'h2)
					cmd_mode_o <= ~config_n_s;
				else if (plus_hit)
					cmd_mode_o <= 1'b1;
				else if (wr_ctrl)
					cmd_mode_o <= pwdata_i[rfm_pkg::CTRL_CMD_MODE];
			end
		end
	end

	// ========================================
	// uart receiver
	rfm_pkg::rfm_rx_state_t rx_state;
	logic [15:0]            rx_cnt;
	logic [2:0]             rx_bit;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_state <= rfm_pkg::RX_IDLE;
			rx_cnt   <= 16'h0000;
			rx_bit   <= 3'h0;
			rx_byte  <= 8'h00;
			rx_done  <= 1'b0;
			rx_ferr  <= 1'b0;
		end
		else if (ce_i)
		begin
			rx_done <= 1'b0;
			rx_ferr <= 1'b0;
			if (clr)
				rx_state <= rfm_pkg::RX_IDLE;
			else if (rx_state != rfm_pkg::RX_IDLE && rx_cnt != 16'h0000)
				rx_cnt <= rx_cnt - 16'h0001;
			else
			begin
				case (rx_state)
					rfm_pkg::RX_IDLE:
						if (!rx_s)
						begin
							rx_state <= rfm_pkg::RX_START;
							rx_cnt   <= baud >> 1;
						end
					rfm_pkg::RX_START:
					begin
						rx_state <= rx_s ? rfm_pkg::RX_IDLE : rfm_pkg::RX_DATA;
						rx_cnt   <= baud - 16'h0001;
						rx_bit   <= 3'h0;
					end
					rfm_pkg::RX_DATA:
					begin
						rx_byte <= {rx_s, rx_byte[7:1]};
						rx_bit  <= rx_bit + 3'h1;
						rx_cnt  <= baud - 16'h0001;
						if (rx_bit == 3'h7)
							rx_state <= rfm_pkg::RX_STOP;
					end
					rfm_pkg::RX_STOP:
					begin
						rx_done  <= rx_s;
						rx_ferr  <= ~rx_s;
						rx_state <= rfm_pkg::RX_IDLE;
					end
					default:
						rx_state <= rfm_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// ========================================
	// input buffer and drain toward the radio
	logic       ib_valid;
	logic [7:0] ib_data;
	logic       ib_pop;

	assign ib_pop = ib_valid & (~rf_tx_valid_o | rf_tx_ready_i) & ~rf_rx_active_i;

	rfm_fifo #(.WIDTH(8), .DEPTH(IB_DEPTH)) u_ib_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.ce_i        (ce_i),
		.clr_i       (clr),
		.in_valid_i  (rx_done & ~cmd_sel),
		.in_data_i   (rx_byte),
		.in_ready_o  (ib_ready),
		.out_valid_o (ib_valid),
		.out_data_o  (ib_data),
		.out_ready_i (ib_pop),
		.level_o     (ib_level)
	);

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rf_tx_valid_o <= 1'b0;
			rf_tx_data_o  <= 8'h00;
		end
		else if (ce_i)
		begin
			if (clr)
				rf_tx_valid_o <= 1'b0;
			else if (ib_pop)
			begin
				rf_tx_valid_o <= 1'b1;
				rf_tx_data_o  <= ib_data;
			end
			else if (rf_tx_ready_i)
				rf_tx_valid_o <= 1'b0;
		end
	end

	// ========================================
	// output buffer and uart transmitter
	rfm_pkg::rfm_tx_state_t tx_state;
	logic [9:0]             tx_frame;
	logic [3:0]             tx_left;
	logic [15:0]            tx_cnt;
	logic                   do_valid;
	logic [7:0]             do_data;
	logic                   tx_pop;

	assign tx_busy = (tx_state != rfm_pkg::TX_IDLE);
	assign tx_pop  = do_valid & ~tx_busy & ~clr & ((ctrl.rts_mode != rfm_pkg::RTS_FLOW) | ~aux2_s);

	rfm_fifo #(.WIDTH(8), .DEPTH(DO_DEPTH)) u_do_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.ce_i        (ce_i),
		.clr_i       (clr),
		.in_valid_i  (rf_rx_valid_i),
		.in_data_i   (rf_rx_data_i),
		.in_ready_o  (rf_rx_ready_o),
		.out_valid_o (do_valid),
		.out_data_o  (do_data),
		.out_ready_i (tx_pop),
		.level_o     ()
	);

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_state         <= rfm_pkg::TX_IDLE;
			tx_frame         <= 10'h3FF;
			tx_left          <= 4'h0;
			tx_cnt           <= 16'h0000;
			serial_out_pin_o <= 1'b1;
		end
		else if (ce_i)
		begin
			case (tx_state)
				rfm_pkg::TX_IDLE:
				begin
					serial_out_pin_o <= 1'b1;
					if (tx_pop)
					begin
						tx_frame         <= {1'b1, do_data, 1'b0};
						tx_left          <= 4'h9;
						tx_cnt           <= baud - 16'h0001;
						serial_out_pin_o <= 1'b0;
						tx_state         <= rfm_pkg::TX_BITS;
					end
				end
				rfm_pkg::TX_BITS:
					if (clr)
						tx_state <= rfm_pkg::TX_IDLE;
					else if (tx_cnt != 16'h0000)
						tx_cnt <= tx_cnt - 16'h0001;
					else if (tx_left == 4'h0)
						tx_state <= rfm_pkg::TX_IDLE;
					else
					begin
						serial_out_pin_o <= tx_frame[1];
						tx_frame         <= {1'b1, tx_frame[9:1]};
						tx_left          <= tx_left - 4'h1;
						tx_cnt           <= baud - 16'h0001;
					end
				default:
					tx_state <= rfm_pkg::TX_IDLE;
			endcase
		end
	end

	// ========================================
	// flow control pin and status pins
	logic [DLW:0] ib_free;

	assign ib_free = (DLW+1)'(IB_DEPTH) - (DLW+1)'(ib_level);

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cts_hold                <= 1'b0;
			aux_output_two_o        <= 1'b0;
			sleep_o                 <= 1'b0;
			receive_indicator_o     <= 1'b0;
			transmit_power_status_o <= 1'b0;
		end
		else if (ce_i)
		begin
			// hysteresis keeps the host from chattering near the threshold
			if (clr)
				cts_hold <= 1'b0;
			else if (ib_free <= (DLW+1)'(fc_off))
				cts_hold <= 1'b1;
			else if (ib_free >= (DLW+1)'(fc_on))
				cts_hold <= 1'b0;
			// driver enable lags the frame end by one cycle
			if (ctrl.cts_mode == rfm_pkg::CTS_FLOW)
				aux_output_two_o <= cts_hold;
			else
				aux_output_two_o <= tx_pop | tx_busy;
			sleep_o                 <= ctrl.sleep_en & aux3_s & ~clr;
			receive_indicator_o     <= ctrl.rx_ind_en & rf_rx_active_i & ~clr;
			transmit_power_status_o <= ~sleep_o & ~(rf_tx_valid_o | rf_tx_busy_i) & ~clr;
		end
	end
endmodule
`default_nettype wire

/* File: tb/rfm_pin_if_properties.sv */
`default_nettype none
// ========================================
// pin interface checker
module rfm_pin_if_properties #(
	parameter int BAUD_DIV = 16
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       pready_o,
	input  wire logic       pslverr_o,
	input  wire logic       serial_out_pin_o,
	input  wire logic       aux_input_three_i,
	input  wire logic       reset_pin_n_i,
	input  wire logic       receive_indicator_o,
	input  wire logic       transmit_power_status_o,
	input  wire logic       sleep_o,
	input  wire logic       cmd_mode_o,
	input  wire logic [7:0] rf_tx_data_o,
	input  wire logic       rf_tx_valid_o,
	input  wire logic       rf_tx_ready_i,
	input  wire logic       rf_tx_busy_i,
	input  wire logic       rf_rx_active_i
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic [15:0] low_run;
	logic        dirty;

	// ========================================
	// helper logic
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			low_run <= 16'h0000;
		else if (!serial_out_pin_o)
			low_run <= low_run + 16'h0001;
		else
			low_run <= 16'h0000;
	end

	// a stretch cut short by the reset pin is no frame, so skip its end
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			dirty <= 1'b0;
		else if (!reset_pin_n_i)
			dirty <= 1'b1;
		else if (serial_out_pin_o)
			dirty <= 1'b0;
	end

	// ========================================
	// assertions
	a_rxind_idle: assert property (!$past(rf_rx_active_i) |-> !receive_indicator_o)
		else $error("receive indicator high without reception");
	a_txstat_busy: assert property ($past(rf_tx_busy_i || rf_tx_valid_o)
		|-> !transmit_power_status_o) else $error("status high during transmission");
	a_txstat_sleep: assert property ($past(sleep_o) |-> !transmit_power_status_o)
		else $error("status high while sleeping");
	a_sleep_pin: assert property ($rose(sleep_o) |-> $past(aux_input_three_i, 3))
		else $error("sleep entered without request pin");
	a_rftx_hold: assert property (rf_tx_valid_o && !rf_tx_ready_i && reset_pin_n_i
		&& $past(reset_pin_n_i) && $past(reset_pin_n_i, 2) && $past(reset_pin_n_i, 3)
		|=> rf_tx_valid_o && $stable(rf_tx_data_o)) else $error("radio byte dropped");
	a_rftx_blocked: assert property ($rose(rf_tx_valid_o) |-> !$past(rf_rx_active_i))
		else $error("radio byte offered during reception");
	a_serout_bits: assert property ($rose(serial_out_pin_o) && !dirty
		|-> low_run != 16'h0000 && (low_run % BAUD_DIV) == 0)
		else $error("serial low stretch not whole bits");
	a_pready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	a_slverr_ready: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");

	cover property ($rose(sleep_o));
	cover property ($rose(cmd_mode_o));
	cover property ($fell(serial_out_pin_o));
	cover property (rf_tx_valid_o && rf_tx_ready_i);
endmodule

bind rfm_pin_if rfm_pin_if_properties #(.BAUD_DIV(BAUD_DIV)) rfm_pin_if_properties_inst (
	.clk_i(clk_i), .reset_i(reset_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.serial_out_pin_o(serial_out_pin_o), .aux_input_three_i(aux_input_three_i),
	.reset_pin_n_i(reset_pin_n_i), .receive_indicator_o(receive_indicator_o),
	.transmit_power_status_o(transmit_power_status_o), .sleep_o(sleep_o),
	.cmd_mode_o(cmd_mode_o), .rf_tx_data_o(rf_tx_data_o), .rf_tx_valid_o(rf_tx_valid_o),
	.rf_tx_ready_i(rf_tx_ready_i), .rf_tx_busy_i(rf_tx_busy_i), .rf_rx_active_i(rf_rx_active_i)
);
`default_nettype wire

/* File: tb/rfm_host_model.sv */
`default_nettype none
// ========================================
// uart host on the far side of the pins
module rfm_host_model #(
	parameter int BAUD_DIV = 16
) (
	input  wire logic clk_i,
	input  wire logic cts_i,
	input  wire logic serial_i,
	output logic      serial_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rx_q[$];
	logic [7:0] rx_b;
	int         frame_errs;

	initial serial_o = 1'b1;

	// waits for clear-to-send before each byte, never inside one
	task automatic send_byte(input logic [7:0] b);
		int         n;
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (n = 0; cts_i !== 1'b0 && n < 20000; n++) @(posedge clk_i);
		@(posedge clk_i);
		for (n = 0; n < 10; n++)
		begin
			serial_o <= fr[n];
			repeat (BAUD_DIV) @(posedge clk_i);
		end
	endtask

	// mid-bit sampling of the module's serial output
	initial
	begin
		frame_errs = 0;
		forever
		begin
			@(negedge serial_i);
			repeat (BAUD_DIV / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BAUD_DIV) @(posedge clk_i);
				rx_b[i] = serial_i;
			end
			repeat (BAUD_DIV) @(posedge clk_i);
			if (serial_i !== 1'b1)
				frame_errs++;
			rx_q.push_back(rx_b);
		end
	end
endmodule
`default_nettype wire

/* File: tb/rfm_pin_if_tb.sv */
`default_nettype none
module rfm_pin_if_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BAUD = 16;
	logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [7:0]  paddr, rf_rx_data, tx_data;
	logic [31:0] pwdata, prdata, rd_val;
	logic        ser_in, ser_out, cts, rts_n, aux3, rst_pin_n, config_n, rx_ind, transmit_power_status;
	logic        sleep, cmd_mode, tx_valid, tx_ready, tx_busy, rx_valid, rx_ready, rx_active;
	int          bad_count, num_checks, n;

	rfm_pin_if #(.BAUD_DIV(BAUD)) rfm_pin_if_inst (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .serial_in_pin_i(ser_in),
		.serial_out_pin_o(ser_out), .aux_output_two_o(cts), .aux_input_two_i(rts_n),
		.aux_input_three_i(aux3), .reset_pin_n_i(rst_pin_n), .config_n_i(config_n),
		.receive_indicator_o(rx_ind), .transmit_power_status_o(transmit_power_status), .sleep_o(sleep),
		.cmd_mode_o(cmd_mode), .rf_tx_data_o(tx_data), .rf_tx_valid_o(tx_valid),
		.rf_tx_ready_i(tx_ready), .rf_tx_busy_i(tx_busy), .rf_rx_data_i(rf_rx_data),
		.rf_rx_valid_i(rx_valid), .rf_rx_ready_o(rx_ready), .rf_rx_active_i(rx_active));
	rfm_host_model #(.BAUD_DIV(BAUD)) rfm_host_model_inst (
		.clk_i(clk_i), .cts_i(cts), .serial_i(ser_out), .serial_o(ser_in));

	always #5 clk_i = ~clk_i;

	// ========================================
	// shared tasks
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do
			@(posedge clk_i);
		while (pready !== 1'b1);
		rd_val = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd_val);
	endtask

	// ========================================
	// scenarios
	task automatic t_regs();
		chk("serial idle", 1, ser_out);
		chk("cts after reset", 0, cts);
		chk("status awake", 1, transmit_power_status);
		chk("cmd mode", 0, cmd_mode);
		rd(rfm_pkg::OFF_CTRL, 32'h0000_0000, "ctrl");
		rd(rfm_pkg::OFF_BAUD, 32'h0000_0010, "baud");
		rd(rfm_pkg::OFF_FLOW, 32'h0000_2211, "flow");
		rd(8'h14, 32'h0000_0000, "unmapped data");
		chk("unmapped err", 1, rd_err);
		$display("regs done");
	endtask

	task automatic t_rf_tx();
		rx_active <= 1'b1;
		rfm_host_model_inst.send_byte(8'hA5);
		rd(rfm_pkg::OFF_STATUS, 32'h0000_0108, "held status");
		chk("held valid", 0, tx_valid);
		rx_active <= 1'b0;
		for (n = 0; n < 20 && tx_valid !== 1'b1; n++) @(posedge clk_i);
		chk("rf byte", 8'hA5, tx_data);
		tx_ready <= 1'b1;
		repeat (3) @(posedge clk_i);
		tx_busy <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("status in tx", 0, transmit_power_status);
		tx_busy <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("status after tx", 1, transmit_power_status);
		$display("rf tx done");
	endtask

	task automatic t_rf_rx();
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0025);
		rx_active <= 1'b1;
		rf_rx_data <= 8'h3C;
		rx_valid <= 1'b1;
		for (n = 0; n < 20 && rx_ready !== 1'b1; n++) @(posedge clk_i);
		chk("rx fifo ready", 1, rx_ready);
		@(posedge clk_i);
		rx_valid <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("rx indicator", 1, rx_ind);
		repeat (3 * BAUD) @(posedge clk_i);
		chk("gated output", 1, ser_out);
		chk("driver idle", 0, cts);
		rts_n <= 1'b0;
		for (n = 0; n < 100 && ser_out !== 1'b0; n++) @(posedge clk_i);
		repeat (2) @(posedge clk_i);
		chk("driver on", 1, cts);
		for (n = 0; n < 12 * BAUD && rfm_host_model_inst.rx_q.size() == 0; n++) @(posedge clk_i);
		chk("serial byte", 8'h3C, rfm_host_model_inst.rx_q[0]);
		chk("stop bit", 0, rfm_host_model_inst.frame_errs);
		rx_active <= 1'b0;
		rts_n <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("rx indicator off", 0, rx_ind);
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0000);
		$display("rf rx done");
	endtask

	task automatic t_cmd();
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0008);
		rts_n <= 1'b0;
		rfm_host_model_inst.send_byte(8'h5A);
		repeat (4) @(posedge clk_i);
		rd(rfm_pkg::OFF_CMD, 32'h0000_005A, "cmd byte");
		rts_n <= 1'b1;
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0000);
		rfm_host_model_inst.send_byte(rfm_pkg::PLUS_CHAR);
		rfm_host_model_inst.send_byte(rfm_pkg::PLUS_CHAR);
		repeat (4) @(posedge clk_i);
		chk("two plus", 0, cmd_mode);
		rfm_host_model_inst.send_byte(rfm_pkg::PLUS_CHAR);
		repeat (4) @(posedge clk_i);
		chk("three plus", 1, cmd_mode);
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0000);
		chk("cmd cleared", 0, cmd_mode);
		$display("cmd done");
	endtask

	task automatic t_sleep();
		aux3 <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("sleep ignored", 0, sleep);
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0010);
		repeat (8) @(posedge clk_i);
		chk("sleep on", 1, sleep);
		chk("status asleep", 0, transmit_power_status);
		aux3 <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("status woke", 1, transmit_power_status);
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0000);
		$display("sleep done");
	endtask

	// 47 bytes leave exactly 17 free in the 64-byte buffer
	task automatic t_flow();
		rx_active <= 1'b1;
		for (int i = 0; i < 46; i++)
			rfm_host_model_inst.send_byte(i[7:0]);
		repeat (4) @(posedge clk_i);
		chk("cts 18 free", 0, cts);
		rfm_host_model_inst.send_byte(8'h77);
		repeat (4) @(posedge clk_i);
		chk("cts 17 free", 1, cts);
		rx_active <= 1'b0;
		repeat (200) @(posedge clk_i);
		chk("cts drained", 0, cts);
		rd(rfm_pkg::OFF_STATUS, 32'h0000_0000, "drained status");
		$display("flow done");
	endtask

	task automatic t_strap();
		apb(1'b1, rfm_pkg::OFF_CTRL, 32'h0000_0020);
		config_n <= 1'b0;
		rst_pin_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("status in reset", 0, transmit_power_status);
		rst_pin_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("strap cmd mode", 1, cmd_mode);
		rd(rfm_pkg::OFF_CTRL, 32'h0000_0040, "ctrl after pin reset");
		config_n <= 1'b1;
		$display("strap done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ========================================
	// sequence and watchdog
	initial
	begin
		clk_i = 1'b0;
		reset_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rts_n = 1'b1;
		aux3 = 1'b0;
		rst_pin_n = 1'b1;
		config_n = 1'b1;
		tx_ready = 1'b0;
		tx_busy = 1'b0;
		rf_rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_active = 1'b0;
		bad_count = 0;
		num_checks = 0;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_regs();
		t_rf_tx();
		t_rf_rx();
		t_cmd();
		t_sleep();
		t_flow();
		t_strap();
		finish_test();
	end

	// whole run is near 9000 cycles
	initial
	begin
		#(60000 * 10);
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
